// *** src/sdram_ctrl_pkg.sv ***
// Package: constants, enumerations and pin bundle of the SDRAM command controller
package sdram_ctrl_pkg;

	// ==================================================
	// Widths
	localparam int ADDR_W    = 12;
	localparam int BA_W      = 2;
	localparam int BANKS     = 4;
	localparam int DQ_W      = 16;
	localparam int TMR_W     = 16;
	localparam int CNT_W     = 8;
	localparam int REF_W     = 12;
	localparam int OP_W      = 4;
	localparam int BEAT_W    = 4;
	localparam int IDX_W     = 3;
	localparam int MAX_BEATS = 8;

	// ==================================================
	// Timing, each figure in its own unit, cycles derived at 4 ns
	localparam int     CLK_PERIOD_PS = 4000;
	localparam int     T_RCD_NS      = 20;
	localparam int     T_RP_NS       = 20;
	localparam int     T_RC_NS       = 70;
	localparam int     T_WR_CLK      = 2;
	localparam int     T_PWRUP_US    = 200;
	localparam int     T_REF_MS      = 64;
	localparam int     REF_ROWS      = 4096;
	localparam int     RCD_CYC       = (T_RCD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int     RP_CYC        = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int     RC_CYC        = (T_RC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int     WR_CYC        = T_WR_CLK;
	localparam int     MRS_GAP_CYC   = 1;
	localparam int     PDN_EXIT_CYC  = 1;
	localparam int     PWRUP_CYC     = (T_PWRUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Refresh interval rounds down so every row is refreshed inside the period
	localparam longint REF_INT_L     = (longint'(T_REF_MS) * 64'd1000000000)
	                                   / (longint'(REF_ROWS) * CLK_PERIOD_PS);
	localparam int     REF_INT_CYC   = int'(REF_INT_L);
	localparam int     INIT_REFS     = 8;

	// ==================================================
	// Register map and fields
	localparam logic [7:0] REG_CMD       = 8'h00;
	localparam logic [7:0] REG_ADDR      = 8'h04;
	localparam logic [7:0] REG_MODE      = 8'h08;
	localparam logic [7:0] REG_WMASK     = 8'h0C;
	localparam logic [7:0] REG_STATUS    = 8'h10;
	localparam logic [7:0] REG_WBUF      = 8'h40;
	localparam logic [7:0] REG_RBUF      = 8'h60;
	localparam logic [7:0] BUF_SPAN_MASK = 8'hE0;
	localparam int         BUF_IDX_LSB   = 2;
	localparam int         CMD_AP_BIT    = 4;
	localparam int         ADDR_BANK_LSB = 12;
	localparam int         MODE_BL_LSB   = 0;
	localparam int         MODE_BT_BIT   = 3;
	localparam int         MODE_CL_LSB   = 4;
	localparam logic [ADDR_W-1:0] MODE_RST = 12'h020;
	localparam logic [ADDR_W-1:0] ADDR_ALL = 12'h400;
	localparam logic [2:0]        BL_FULL  = 3'h7;
	localparam int STB_BUSY     = 0;
	localparam int STB_INIT     = 1;
	localparam int STB_SREF     = 2;
	localparam int STB_PDN      = 3;
	localparam int STB_REFUSED  = 4;
	localparam int STB_OPEN_LSB = 8;

	// ==================================================
	// Pin command patterns {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMDP_NOP   = 4'h7;
	localparam logic [3:0] CMDP_ACT   = 4'h3;
	localparam logic [3:0] CMDP_READ  = 4'h5;
	localparam logic [3:0] CMDP_WRITE = 4'h4;
	localparam logic [3:0] CMDP_PRE   = 4'h2;
	localparam logic [3:0] CMDP_REF   = 4'h1;
	localparam logic [3:0] CMDP_MRS   = 4'h0;
	localparam logic [3:0] CMDP_BST   = 4'h6;

	typedef enum logic [OP_W-1:0] {
		OP_NOP = 4'h0, OP_ACT = 4'h1, OP_READ = 4'h2, OP_WRITE = 4'h3,
		OP_PRE = 4'h4, OP_REF = 4'h5, OP_MRS = 4'h6, OP_BST = 4'h7,
		OP_SREF = 4'h8, OP_PDN = 4'h9, OP_WAKE = 4'hA
	} op_e;

	typedef enum logic [3:0] {
		ST_PWRUP = 4'h0, ST_INIT_PRE = 4'h1, ST_INIT_REF = 4'h3, ST_INIT_MRS = 4'h2,
		ST_IDLE = 4'h6, ST_WAIT = 4'h7, ST_RBURST = 4'h5, ST_WBURST = 4'h4,
		ST_LOWPWR = 4'hC
	} state_e;

	typedef struct packed {
		logic              cke;
		logic [3:0]        cmd;
		logic [BA_W-1:0]   ba;
		logic [ADDR_W-1:0] addr;
		logic              dqm;
	} sd_pins_s;

	localparam sd_pins_s PINS_RST = '{cke: 1'b1, cmd: CMDP_NOP, ba: '0, addr: '0, dqm: 1'b1};

endpackage

// *** src/cycle_timer.sv ***
// Down-counting wait timer used to space SDRAM commands
`timescale 1ns/1ps
module cycle_timer
	import sdram_ctrl_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             load,
	input  wire logic [TMR_W-1:0] load_val,
	output logic                  done
);

	logic [TMR_W-1:0] cnt_q;

	// A pending load hides a stale zero from the previous wait
	assign done = (cnt_q == '0) && !load;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q <= '0;
		end else if (ce) begin
			if (load) begin
				cnt_q <= load_val;
			end else if (cnt_q != '0) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end

endmodule // cycle_timer

// *** src/sdram_host_ctrl.sv ***
// SDRAM command controller: APB register front end driving the memory pins
//
// Overview of operation
// - Mode register is programmed after precharge-all, before any row activation.
// - A NOP always follows a mode set command.
// - Column command waits row_to_column_delay after activate; WE picks read/write.
// - Read interrupted by write must be masked to avoid bus collision.
// - All banks precharged before either refresh mode.
// - Auto refresh, then row cycle time before next refresh or access.
// - Self refresh with CKE low; row cycle time after CKE rises.
// - Power down only with all banks precharged and precharge time elapsed.
// - Leave power down before the refresh period runs out.
// - Precharge after write waits write recovery past last data.
`timescale 1ns/1ps
module sdram_host_ctrl
	import sdram_ctrl_pkg::*;
#(
	parameter int PWRUP_CYCLES = PWRUP_CYC
) (
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic              CE,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	output logic                   SD_CKE,
	output logic                   SD_CS_N,
	output logic                   SD_RAS_N,
	output logic                   SD_CAS_N,
	output logic                   SD_WE_N,
	output logic      [BA_W-1:0]   SD_BA,
	output logic      [ADDR_W-1:0] SD_ADDR,
	output logic                   SD_DQM,
	input  wire logic [DQ_W-1:0]   SD_DQ_I,
	output logic      [DQ_W-1:0]   SD_DQ_O,
	output logic                   SD_DQ_OE_N
);

	// ==================================================
	// State
	state_e                  state_q;
	state_e                  ret_q;
	sd_pins_s                pins_q;
	logic [DQ_W-1:0]         dq_out_q;
	logic                    dq_oe_n_q;
	logic [ADDR_W+BA_W-1:0]  addr_q;
	logic [ADDR_W-1:0]       mode_q;
	logic [MAX_BEATS-1:0]    wmask_q;
	logic [DQ_W-1:0]         wbuf_q [MAX_BEATS];
	logic [DQ_W-1:0]         rbuf_q [MAX_BEATS];
	logic [BANKS-1:0]        open_q;
	logic [BA_W-1:0]         cur_bank_q;
	logic                    cur_ap_q;
	logic [BEAT_W-1:0]       beat_q;
	logic                    init_done_q;
	logic [BEAT_W-1:0]       init_refs_q;
	logic                    self_q;
	logic                    refused_q;
	logic                    ref_pend_q;
	logic [REF_W-1:0]        ref_cnt_q;
	logic                    tmr_ld_q;
	logic [TMR_W-1:0]        tmr_val_q;
	logic                    tmr_done;
	logic [31:0]             prdata_q;
	logic [31:0]             rd_mux;

	// ==================================================
	// APB decode
	wire       apb_wr    = PSEL && PENABLE && PWRITE;
	wire       apb_setup = PSEL && !PENABLE;
	wire       hit_wbuf  = (PADDR & BUF_SPAN_MASK) == REG_WBUF;
	wire       hit_rbuf  = (PADDR & BUF_SPAN_MASK) == REG_RBUF;
	wire [IDX_W-1:0] buf_idx = PADDR[BUF_IDX_LSB +: IDX_W];
	wire       mapped    = (PADDR == REG_CMD) || (PADDR == REG_ADDR) || (PADDR == REG_MODE)
	                       || (PADDR == REG_WMASK) || (PADDR == REG_STATUS) || hit_wbuf || hit_rbuf;
	wire       cmd_wr    = apb_wr && (PADDR == REG_CMD);
	wire       stat_wr   = apb_wr && (PADDR == REG_STATUS);
	wire op_e  cmd_op    = op_e'(PWDATA[OP_W-1:0]);
	wire       cmd_ap    = PWDATA[CMD_AP_BIT];

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA  = prdata_q;

	// ==================================================
	// Mode fields and command legality
	wire [2:0]        bl_code  = mode_q[MODE_BL_LSB +: 3];
	wire [2:0]        cl       = mode_q[MODE_CL_LSB +: 3];
	wire              full_pg  = (bl_code == BL_FULL);
	wire [BEAT_W-1:0] beats    = full_pg ? BEAT_W'(MAX_BEATS) : (BEAT_W'(1) << bl_code[1:0]);
	wire [BA_W-1:0]   req_bank = addr_q[ADDR_BANK_LSB +: BA_W];
	wire              bank_open  = open_q[req_bank];
	wire              all_closed = (open_q == '0);
	// Full page cannot be combined with interleaved order
	wire              mode_bad   = full_pg && mode_q[MODE_BT_BIT];
	wire [ADDR_W-1:0] col_addr   = (addr_q[ADDR_W-1:0] & ~ADDR_ALL) | (cmd_ap ? ADDR_ALL : '0);

	// refresh and power down only with all banks closed
	wire cmd_legal =
		(state_q == ST_LOWPWR) ? (cmd_op == OP_WAKE) :
		(state_q != ST_IDLE) ? 1'b0 :
		(cmd_op == OP_ACT) ? (init_done_q && !bank_open) :
		(cmd_op == OP_READ || cmd_op == OP_WRITE) ? bank_open :
		(cmd_op == OP_REF || cmd_op == OP_SREF || cmd_op == OP_PDN) ? all_closed :
		(cmd_op == OP_MRS) ? (all_closed && !mode_bad) :
		(cmd_op == OP_NOP || cmd_op == OP_PRE || cmd_op == OP_BST);
	wire cmd_take = cmd_wr && cmd_legal;

	// ==================================================
	// Read capture window, counted from the edge that registers the read
	wire [4:0]       cap_end = 5'(cl) + 5'(beats);
	wire             cap_en  = ({1'b0, beat_q} >= 5'(cl)) && ({1'b0, beat_q} < cap_end);
	wire [IDX_W-1:0] cap_idx = IDX_W'(beat_q - BEAT_W'(cl));
	wire             rd_last = ({1'b0, beat_q} == cap_end - 5'd1);
	wire [TMR_W-1:0] wr_rec  = cur_ap_q ? TMR_W'(WR_CYC + RP_CYC - 1) : TMR_W'(WR_CYC - 1);

	wire [31:0] status_w = (32'(open_q) << STB_OPEN_LSB) | (32'(refused_q) << STB_REFUSED)
		| (32'(state_q == ST_LOWPWR && !self_q) << STB_PDN)
		| (32'(state_q == ST_LOWPWR && self_q) << STB_SREF)
		| (32'(init_done_q) << STB_INIT) | (32'(state_q != ST_IDLE) << STB_BUSY);

	assign SD_CKE     = pins_q.cke;
	assign SD_CS_N    = pins_q.cmd[3];
	assign SD_RAS_N   = pins_q.cmd[2];
	assign SD_CAS_N   = pins_q.cmd[1];
	assign SD_WE_N    = pins_q.cmd[0];
	assign SD_BA      = pins_q.ba;
	assign SD_ADDR    = pins_q.addr;
	assign SD_DQM     = pins_q.dqm;
	assign SD_DQ_O    = dq_out_q;
	assign SD_DQ_OE_N = dq_oe_n_q;

	cycle_timer u_timer (
		.clk      (CLK),
		.rst      (RST),
		.ce       (CE),
		.load     (tmr_ld_q),
		.load_val (tmr_val_q),
		.done     (tmr_done)
	);

	// ==================================================
	// Register file
	always_comb begin
		rd_mux = '0;
		if (PADDR == REG_ADDR) begin
			rd_mux = 32'(addr_q);
		end else if (PADDR == REG_MODE) begin
			rd_mux = 32'(mode_q);
		end else if (PADDR == REG_WMASK) begin
			rd_mux = 32'(wmask_q);
		end else if (PADDR == REG_STATUS) begin
			rd_mux = status_w;
		end else if (hit_wbuf) begin
			rd_mux = 32'(wbuf_q[buf_idx]);
		end else if (hit_rbuf) begin
			rd_mux = 32'(rbuf_q[buf_idx]);
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			prdata_q  <= '0;
			addr_q    <= '0;
			mode_q    <= MODE_RST;
			wmask_q   <= '0;
			refused_q <= 1'b0;
		end else if (CE) begin
			if (apb_setup) prdata_q <= rd_mux;
			if (apb_wr && PADDR == REG_ADDR) addr_q <= PWDATA[ADDR_W+BA_W-1:0];
			if (apb_wr && PADDR == REG_MODE) mode_q <= PWDATA[ADDR_W-1:0];
			if (apb_wr && PADDR == REG_WMASK) wmask_q <= PWDATA[MAX_BEATS-1:0];
			// A refusal in the same cycle as the clear stays visible
			refused_q <= (cmd_wr && !cmd_legal)
				|| (refused_q && !(stat_wr && PWDATA[STB_REFUSED]));
		end
	end

	always_ff @(posedge CLK) begin
		if (CE && apb_wr && hit_wbuf) wbuf_q[buf_idx] <= PWDATA[DQ_W-1:0];
	end

	// ==================================================
	// Refresh interval timer; cleared before init and in self refresh
	always_ff @(posedge CLK) begin
		if (RST) begin
			ref_cnt_q  <= '0;
			ref_pend_q <= 1'b0;
		end else if (CE) begin
			if (!init_done_q || (state_q == ST_LOWPWR && self_q)) begin
				ref_cnt_q  <= '0;
				ref_pend_q <= 1'b0;
			end else begin
				ref_cnt_q  <= (ref_cnt_q == REF_W'(REF_INT_CYC - 1)) ? '0 : ref_cnt_q + 1'b1;
				ref_pend_q <= (ref_cnt_q == REF_W'(REF_INT_CYC - 1))
					|| (ref_pend_q && !(pins_q.cmd == CMDP_REF));
			end
		end
	end

	// ==================================================
	// Command sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_q     <= ST_PWRUP;
			ret_q       <= ST_IDLE;
			pins_q      <= PINS_RST;
			dq_out_q    <= '0;
			dq_oe_n_q   <= 1'b1;
			open_q      <= '0;
			cur_bank_q  <= '0;
			cur_ap_q    <= 1'b0;
			beat_q      <= '0;
			init_done_q <= 1'b0;
			init_refs_q <= '0;
			self_q      <= 1'b0;
			tmr_ld_q    <= 1'b1;
			tmr_val_q   <= TMR_W'(PWRUP_CYCLES - 1);
		end else if (CE) begin
			pins_q.cmd <= CMDP_NOP;
			pins_q.dqm <= !init_done_q;
			dq_oe_n_q  <= 1'b1;
			tmr_ld_q   <= 1'b0;
			case (state_q)
				ST_PWRUP: begin
					if (tmr_done) begin
						pins_q.cmd  <= CMDP_PRE;
						pins_q.addr <= ADDR_ALL;
						tmr_ld_q    <= 1'b1;
						tmr_val_q   <= TMR_W'(RP_CYC - 1);
						ret_q       <= ST_INIT_REF;
						state_q     <= ST_WAIT;
					end
				end
				ST_INIT_REF: begin
					pins_q.cmd  <= CMDP_REF;
					init_refs_q <= init_refs_q + 1'b1;
					tmr_ld_q    <= 1'b1;
					tmr_val_q   <= TMR_W'(RC_CYC - 1);
					ret_q       <= (init_refs_q == BEAT_W'(INIT_REFS - 1)) ? ST_INIT_MRS : ST_INIT_REF;
					state_q     <= ST_WAIT;
				end
				// mode set closes the power-up sequence
				ST_INIT_MRS: begin
					pins_q.cmd  <= CMDP_MRS;
					pins_q.ba   <= '0;
					pins_q.addr <= mode_q;
					init_done_q <= 1'b1;
					tmr_ld_q    <= 1'b1;
					tmr_val_q   <= TMR_W'(MRS_GAP_CYC - 1);
					ret_q       <= ST_IDLE;
					state_q     <= ST_WAIT;
				end
				// waiting here keeps NOP on the pins after a mode set
				ST_WAIT: begin
					if (tmr_done) state_q <= ret_q;
				end
				ST_IDLE: begin
					ret_q      <= ST_IDLE;
					cur_bank_q <= req_bank;
					cur_ap_q   <= cmd_ap;
					beat_q     <= '0;
					if (cmd_take) begin
						pins_q.ba <= req_bank;
						case (cmd_op)
							OP_ACT: begin
								pins_q.cmd      <= CMDP_ACT;
								pins_q.addr     <= addr_q[ADDR_W-1:0];
								open_q[req_bank] <= 1'b1;
								tmr_ld_q        <= 1'b1;
								tmr_val_q       <= TMR_W'(RCD_CYC - 1);
								state_q         <= ST_WAIT;
							end
							// reads finish before any write, so the bus never collides
							OP_READ: begin
								pins_q.cmd  <= CMDP_READ;
								pins_q.addr <= col_addr;
								state_q     <= ST_RBURST;
							end
							// first word and mask go out with the write command
							OP_WRITE: begin
								pins_q.cmd  <= CMDP_WRITE;
								pins_q.addr <= col_addr;
								pins_q.dqm  <= wmask_q[0];
								dq_out_q    <= wbuf_q[0];
								dq_oe_n_q   <= 1'b0;
								beat_q      <= BEAT_W'(1);
								state_q     <= ST_WBURST;
							end
							// A10 selects all banks, else the bank select pair
							OP_PRE: begin
								pins_q.cmd  <= CMDP_PRE;
								pins_q.addr <= cmd_ap ? ADDR_ALL : '0;
								if (cmd_ap) open_q <= '0;
								else open_q[req_bank] <= 1'b0;
								tmr_ld_q  <= 1'b1;
								tmr_val_q <= TMR_W'(RP_CYC - 1);
								state_q   <= ST_WAIT;
							end
							// row cycle time after an auto refresh
							OP_REF: begin
								pins_q.cmd <= CMDP_REF;
								tmr_ld_q   <= 1'b1;
								tmr_val_q  <= TMR_W'(RC_CYC - 1);
								state_q    <= ST_WAIT;
							end
							OP_MRS: begin
								pins_q.cmd  <= CMDP_MRS;
								pins_q.addr <= mode_q;
								tmr_ld_q    <= 1'b1;
								tmr_val_q   <= TMR_W'(MRS_GAP_CYC - 1);
								state_q     <= ST_WAIT;
							end
							OP_BST: pins_q.cmd <= CMDP_BST;
							// self refresh entry drops CKE with the refresh command
							OP_SREF: begin
								pins_q.cmd <= CMDP_REF;
								pins_q.cke <= 1'b0;
								self_q     <= 1'b1;
								state_q    <= ST_LOWPWR;
							end
							// every wait ends its precharge time before idle
							OP_PDN: begin
								pins_q.cke <= 1'b0;
								self_q     <= 1'b0;
								state_q    <= ST_LOWPWR;
							end
							default: ;
						endcase
					end else if (ref_pend_q && !cmd_wr) begin
						// close open banks before the refresh
						pins_q.cmd  <= all_closed ? CMDP_REF : CMDP_PRE;
						pins_q.addr <= ADDR_ALL;
						open_q      <= '0;
						tmr_ld_q    <= 1'b1;
						tmr_val_q   <= all_closed ? TMR_W'(RC_CYC - 1) : TMR_W'(RP_CYC - 1);
						state_q     <= ST_WAIT;
					end
				end
				// a due refresh wakes the device from power down
				ST_LOWPWR: begin
					if (cmd_take || (!self_q && ref_pend_q)) begin
						pins_q.cke <= 1'b1;
						tmr_ld_q   <= 1'b1;
						tmr_val_q  <= self_q ? TMR_W'(RC_CYC - 1) : TMR_W'(PDN_EXIT_CYC - 1);
						self_q     <= 1'b0;
						state_q    <= ST_WAIT;
					end
				end
				// capture one programmed burst, at most eight words
				ST_RBURST: begin
					beat_q <= beat_q + 1'b1;
					if (cap_en) rbuf_q[cap_idx] <= SD_DQ_I;
					// full page never ends by itself, so stop it
					if (full_pg && beat_q == BEAT_W'(MAX_BEATS - 1)) pins_q.cmd <= CMDP_BST;
					if (rd_last) begin
						// auto precharge closes the bank; wait its precharge time
						if (cur_ap_q) open_q[cur_bank_q] <= 1'b0;
						tmr_ld_q  <= 1'b1;
						tmr_val_q <= TMR_W'(RP_CYC - 1);
						state_q   <= cur_ap_q ? ST_WAIT : ST_IDLE;
					end
				end
				ST_WBURST: begin
					if (beat_q == beats) begin
						// burst stop with masked bus ends a full page write
						if (full_pg) pins_q.cmd <= CMDP_BST;
						pins_q.dqm <= 1'b1;
						if (cur_ap_q) open_q[cur_bank_q] <= 1'b0;
						tmr_ld_q  <= 1'b1;
						tmr_val_q <= wr_rec;
						state_q   <= ST_WAIT;
					end else begin
						// per-beat mask keeps masked words out of memory
						pins_q.dqm <= wmask_q[beat_q[IDX_W-1:0]];
						dq_out_q   <= wbuf_q[beat_q[IDX_W-1:0]];
						dq_oe_n_q  <= 1'b0;
						beat_q     <= beat_q + 1'b1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ==================================================
	// Checks
	wire is_act = pins_q.cmd == CMDP_ACT;
	wire is_col = pins_q.cmd == CMDP_READ || pins_q.cmd == CMDP_WRITE;
	wire is_ref = pins_q.cmd == CMDP_REF;
	logic [CNT_W-1:0] since_act_q;
	logic [CNT_W-1:0] since_ref_q;
	logic [CNT_W-1:0] since_wr_q;

	always_ff @(posedge CLK) begin
		if (RST) begin
			since_act_q <= '1;
			since_ref_q <= '1;
			since_wr_q  <= '1;
		end else if (CE) begin
			since_act_q <= is_act ? '0 : since_act_q + CNT_W'(since_act_q != '1);
			since_ref_q <= (is_ref || !pins_q.cke) ? '0 : since_ref_q + CNT_W'(since_ref_q != '1);
			since_wr_q  <= !dq_oe_n_q ? '0 : since_wr_q + CNT_W'(since_wr_q != '1);
		end
	end

	act_after_init_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		is_act |-> init_done_q && $past(init_done_q)) else $error("activate before mode set");
	mrs_then_nop_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		pins_q.cmd == CMDP_MRS |=> pins_q.cmd == CMDP_NOP) else $error("no NOP after mode set");
	col_after_rcd_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		is_col |-> since_act_q >= CNT_W'(RCD_CYC - 1)) else $error("column too early");
	ref_banks_closed_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		is_ref |-> open_q == '0) else $error("refresh with open bank");
	access_after_rc_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		(is_act || is_col || is_ref) |-> since_ref_q >= CNT_W'(RC_CYC - 1))
		else $error("access inside row cycle time");
	pdn_banks_closed_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		$fell(pins_q.cke) |-> open_q == '0) else $error("power down with open bank");
	pre_after_wr_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		pins_q.cmd == CMDP_PRE |-> since_wr_q >= CNT_W'(WR_CYC - 1))
		else $error("precharge inside write recovery");
	wdata_with_cmd_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		pins_q.cmd == CMDP_WRITE |-> !dq_oe_n_q) else $error("write without data");
	pdn_wake_a: assert property (@(posedge CLK) disable iff (RST || !CE)
		state_q == ST_LOWPWR && !self_q && ref_pend_q |=> pins_q.cke)
		else $error("refresh due in power down");

endmodule // sdram_host_ctrl

// *** verification/sdram_model.sv ***
// Behavioural SDRAM device facing the controller pins
`timescale 1ns/1ps
module sdram_model
	import sdram_ctrl_pkg::*;
(
	input  wire logic [DQ_W-1:0] DQ_I,
	input  wire logic            CLK,
	input  wire sd_pins_s        PINS,
	output logic      [DQ_W-1:0] DQ_O
);
	// Beat count parked above any burst length means no burst runs
	localparam int PARK = 200;
	logic [ADDR_W-1:0] mode_q = MODE_RST;
	logic [DQ_W-1:0]   mem_q [8] = '{default: '0};
	logic [2:0]        col_q = '0;
	logic              dm_q = 1'b1;
	int                rb_q = PARK;
	int                wb_q = PARK;
	initial DQ_O = '0;
	function automatic logic [2:0] at(input logic [2:0] c, input int n);
		logic [2:0] m;
		m = 3'((1 << mode_q[2:0]) - 1);
		return mode_q[3] ? c ^ 3'(n) : (c & ~m) | ((c + 3'(n)) & m);
	endfunction
	always @(posedge CLK) begin : step
		logic rd, wr, cut;
		logic [2:0] c;
		int rn, wn, len;
		rd = PINS.cke && PINS.cmd == CMDP_READ;
		wr = PINS.cke && PINS.cmd == CMDP_WRITE;
		// precharge or mode set ends any burst
		cut = PINS.cke && (PINS.cmd == CMDP_PRE || PINS.cmd == CMDP_MRS);
		// full page runs 128 beats unless something cuts it first
		len = 1 << mode_q[2:0];
		// a new column command restarts a whole burst
		c = (rd || wr) ? PINS.addr[2:0] : col_q;
		rn = rd ? 1 - int'(mode_q[6:4]) : cut ? PARK : rb_q + int'(rb_q < PARK);
		// burst stop drops the rest of a write burst
		wn = wr ? 0 : (cut || (PINS.cke && PINS.cmd == CMDP_BST)) ? PARK
			: wb_q + int'(wb_q < PARK);
		// burst position holds while the clock is suspended
		if (PINS.cke) begin
			col_q <= c;
			rb_q <= rn;
			wb_q <= wn;
		end
		dm_q <= PINS.dqm;
		if (PINS.cke && PINS.cmd == CMDP_MRS) mode_q <= PINS.addr;
		if (PINS.cke && wn < len && !PINS.dqm) mem_q[at(c, wn)] <= DQ_I;
		// mask seen an edge ago floats the next word; idle bus toggles
		DQ_O <= (rn >= 0 && rn < len && !dm_q) ? mem_q[at(c, rn)] : ~DQ_O;
	end
endmodule // sdram_model

// *** verification/test_sdram_host_ctrl.sv ***
// Self-checking bench: APB master against the device model
`timescale 1ns/1ps
module test_sdram_host_ctrl;
	import sdram_ctrl_pkg::*;
	logic CLK = 0, RST = 1, psel = 0, penable = 0, pwrite = 0, pslverr, pready, oe_n, e;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [DQ_W-1:0] dq, ctl_o, mdl_o;
	logic [15:0] w [8];
	wire sd_pins_s pins;
	int errors = 0, checks_done = 0;
	int bl = 4;
	always #2 CLK = ~CLK;
	assign dq = oe_n ? mdl_o : ctl_o;
	sdram_host_ctrl #(.PWRUP_CYCLES(20)) uut (.CLK(CLK), .RST(RST), .CE(1'b1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .SD_CKE(pins.cke), .SD_CS_N(pins.cmd[3]),
		.SD_RAS_N(pins.cmd[2]), .SD_CAS_N(pins.cmd[1]), .SD_WE_N(pins.cmd[0]), .SD_BA(pins.ba),
		.SD_ADDR(pins.addr), .SD_DQM(pins.dqm), .SD_DQ_I(dq), .SD_DQ_O(ctl_o), .SD_DQ_OE_N(oe_n));
	sdram_model partner (.DQ_I(dq), .CLK(CLK), .PINS(pins), .DQ_O(mdl_o));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge CLK);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge CLK);
		penable <= 1;
		do @(posedge CLK); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50) begin
			errors++;
			print_verdict();
		end
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Poll a status bit with a bounded count
	task automatic wt(input int b, input logic v);
		for (int i = 0; i < 300; i++) begin
			apb(0, REG_STATUS, 0);
			if (r[b] === v) return;
		end
		errors++;
		print_verdict();
	endtask
	task automatic op(input logic [31:0] c);
		apb(1, REG_CMD, c);
		wt(STB_BUSY, 0);
	endtask
	// Word expected at column j after a write at column 1, beat 2 masked
	function automatic logic [31:0] exp(input int k, input int j);
		if (j == 3) return 0;
		return 32'(k == 1 ? w[j ^ 1] : w[(j + bl - 1) % bl]);
	endfunction
	initial begin
		void'($urandom(32'hcaa73429));
		repeat (5) @(posedge CLK);
		RST <= 0;
		apb(0, REG_MODE, 0);
		chk(r, 32'(MODE_RST));
		apb(0, 8'h20, 0);
		chk({r[30:0], e}, 32'h1);
		wt(STB_INIT, 1);
		op(2);
		chk(32'(r[STB_REFUSED]), 32'h1);
		for (int k = 0; k < 3; k++) begin
			bl = k == 2 ? 8 : 4;
			apb(1, REG_MODE, k == 2 ? 32'h037 : k ? 32'h02A : 32'h022);
			op(6);
			op(1);
			chk(32'(r[STB_OPEN_LSB +: BANKS]), 32'h1);
			for (int i = 0; i < bl; i++) begin
				w[i] = 16'($urandom);
				apb(1, REG_WBUF + 8'(4 * i), 32'(w[i]));
			end
			apb(1, REG_WMASK, 32'h4);
			apb(1, REG_ADDR, 1);
			op(3);
			apb(1, REG_ADDR, 0);
			op(k == 1 ? 32'h12 : 32'h2);
			chk(32'(r[STB_OPEN_LSB +: BANKS]), k == 1 ? 32'h0 : 32'h1);
			for (int j = 0; j < bl; j++) begin
				apb(0, REG_RBUF + 8'(4 * j), 0);
				chk(r, exp(k, j));
			end
			op(32'h14);
			chk(32'(r[STB_OPEN_LSB +: BANKS]), 32'h0);
		end
		for (int p = 0; p < 2; p++) begin
			apb(1, REG_CMD, 32'(8 + p));
			apb(0, REG_STATUS, 0);
			chk(32'({r[STB_SREF + p], pins.cke}), 32'h2);
			op(10);
			chk(32'(pins.cke), 32'h1);
		end
		print_verdict();
	end
endmodule // test_sdram_host_ctrl
